// ### hdl/rtcr_time_regs.sv
// Time-value register bank and alarm repeat counter behind an AXI4-Lite slave.
// Assumes alarm_event is a one-cycle pulse from logic on clk.
//
// Design decision made here: the AXI4-Lite register port.
`include "rtcr_regs.svh"
module rtcr_time_regs
  import rtcr_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic alarm_event,
  input wire logic [13:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [13:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic alarm_on,
  output logic repeat_event
);

  // ----------------------------------------------------------------
  // Reset synchroniser
  // ----------------------------------------------------------------
  logic rst_meta_reg;
  logic rst_sync_reg;
  wire rst_n = rst_sync_reg;

  // Release only; assertion stays asynchronous
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // Write channel: address and data captured in either order
  // ----------------------------------------------------------------
  logic aw_held_reg;
  logic w_held_reg;
  logic [13:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic awready_reg;
  logic wready_reg;

  // A half is taken only at a real handshake on its own ready
  wire aw_take = s_axi_awvalid && awready_reg;
  wire w_take = s_axi_wvalid && wready_reg;
  wire aw_have = aw_held_reg || aw_take;
  wire w_have = w_held_reg || w_take;
  wire [13:0] wr_addr = aw_held_reg ? awaddr_reg : s_axi_awaddr;
  wire [31:0] wr_data = w_held_reg ? wdata_reg : s_axi_wdata;
  wire [3:0] wr_strb = w_held_reg ? wstrb_reg : s_axi_wstrb;
  // One write retires in the cycle both halves are present
  wire wr_fire = aw_have && w_have && !bvalid_reg;

  wire [11:0] wr_idx = wr_addr[13:2];
  wire wr_ctrl = wr_fire && (wr_idx == `RTCR_IDX_CTRL) && wr_strb[0];
  wire wr_win_lo = wr_fire && (wr_idx == `RTCR_IDX_WIN) && wr_strb[0];
  wire wr_win_hi = wr_fire && (wr_idx == `RTCR_IDX_WIN) && wr_strb[1];
  wire wr_rpt = wr_fire && (wr_idx == `RTCR_IDX_REPEAT) && wr_strb[0];
  wire wr_mapped = (wr_idx == `RTCR_IDX_CTRL) || (wr_idx == `RTCR_IDX_WIN) ||
                   (wr_idx == `RTCR_IDX_REPEAT) || (wr_idx == `RTCR_IDX_EVENT);

  // Hold address and data until the partner half arrives
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= 14'h0000;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
    end else begin
      aw_held_reg <= aw_have && !wr_fire;
      w_held_reg <= w_have && !wr_fire;
      if (aw_take) awaddr_reg <= s_axi_awaddr;
      if (w_take) begin
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
    end
  end

  // Response one cycle after retirement
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= `RTCR_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= wr_mapped ? `RTCR_RESP_OKAY : `RTCR_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Control bits and window pointer
  // ----------------------------------------------------------------
  logic [1:0] ptr_reg;
  logic unlock_reg;
  logic chime_reg;
  logic alarm_on_reg;
  logic [7:0] repeat_reg;
  logic rd_win_hi;

  // Pointer steps down on any high-byte access and parks at zero
  wire hi_access = wr_win_hi || rd_win_hi;
  wire [1:0] ptr_next = wr_ctrl ? wr_data[`RTCR_CTRL_PTR_LO +: 2] :
                        (hi_access && ptr_reg != 2'h0) ? ptr_reg - 2'h1 : ptr_reg;
  // Alarm enable drops after the last event when chime is off
  wire alarm_stop = alarm_event && alarm_on_reg && repeat_reg == 8'h00 && !chime_reg;
  wire alarm_on_next = wr_ctrl ? wr_data[`RTCR_CTRL_ALARM_ON] : (alarm_stop ? 1'b0 : alarm_on_reg);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ptr_reg <= `RTCR_PTR_RST;
      unlock_reg <= 1'b0;
      chime_reg <= 1'b0;
      alarm_on_reg <= 1'b0;
    end else begin
      ptr_reg <= ptr_next;
      alarm_on_reg <= alarm_on_next;
      if (wr_ctrl) begin
        unlock_reg <= wr_data[`RTCR_CTRL_UNLOCK];
        chime_reg <= wr_data[`RTCR_CTRL_CHIME];
      end
    end
  end

  // ----------------------------------------------------------------
  // Repeat counter
  // ----------------------------------------------------------------
  // Wrap from zero only with chime; a software write wins
  wire rpt_dec = alarm_event && (repeat_reg != 8'h00 || chime_reg);
  wire [7:0] repeat_next = wr_rpt ? wr_data[7:0] : (rpt_dec ? repeat_reg - 8'h01 : repeat_reg);
  logic repeat_event_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      repeat_reg <= `RTCR_REPEAT_RST;
      repeat_event_reg <= 1'b0;
    end else begin
      repeat_reg <= repeat_next;
      repeat_event_reg <= alarm_event && alarm_on_reg;
    end
  end

  // ----------------------------------------------------------------
  // Time value storage, no reset by design
  // ----------------------------------------------------------------
  logic [7:0] year_reg;
  logic [7:0] month_reg;
  logic [7:0] day_reg;
  logic [7:0] weekday_digit_reg;
  logic [7:0] hour_reg;
  logic [7:0] min_reg;
  logic [7:0] sec_reg;

  // Locked writes fall away; reserved slot stores nothing
  wire wlo = wr_win_lo && unlock_reg;
  wire whi = wr_win_hi && unlock_reg;
  wire [7:0] wd_lo = wr_data[`RTCR_WIN_LOW_LO +: 8];
  wire [7:0] wd_hi = wr_data[`RTCR_WIN_HIGH_LO +: 8];

  // Contents undefined until software loads a time
  always_ff @(posedge clk) begin
    if (wlo && ptr_reg == RTCR_PTR_MIN_SEC) sec_reg <= wd_lo & `RTCR_MASK_SEC;
    if (whi && ptr_reg == RTCR_PTR_MIN_SEC) min_reg <= wd_hi & `RTCR_MASK_MIN;
    if (wlo && ptr_reg == RTCR_PTR_WEEKDAY_DIGIT_HOUR) hour_reg <= wd_lo & `RTCR_MASK_HOUR;
    if (whi && ptr_reg == RTCR_PTR_WEEKDAY_DIGIT_HOUR) weekday_digit_reg <= wd_hi & `RTCR_MASK_WEEKDAY_DIGIT;
    if (wlo && ptr_reg == RTCR_PTR_MONTH_DAY) day_reg <= wd_lo & `RTCR_MASK_DAY;
    if (whi && ptr_reg == RTCR_PTR_MONTH_DAY) month_reg <= wd_hi & `RTCR_MASK_MONTH;
    if (wlo && ptr_reg == RTCR_PTR_RSVD_YEAR) year_reg <= wd_lo & `RTCR_MASK_YEAR;
  end

  // Pair selection by pointer
  wire [7:0] win_lo = (ptr_reg == RTCR_PTR_MIN_SEC) ? sec_reg :
                      (ptr_reg == RTCR_PTR_WEEKDAY_DIGIT_HOUR) ? hour_reg :
                      (ptr_reg == RTCR_PTR_MONTH_DAY) ? day_reg : year_reg;
  wire [7:0] win_hi = (ptr_reg == RTCR_PTR_MIN_SEC) ? min_reg :
                      (ptr_reg == RTCR_PTR_WEEKDAY_DIGIT_HOUR) ? weekday_digit_reg :
                      (ptr_reg == RTCR_PTR_MONTH_DAY) ? month_reg : 8'h00;

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic arready_reg;

  wire rd_take = s_axi_arvalid && arready_reg;
  wire [11:0] rd_idx = s_axi_araddr[13:2];
  wire rd_is_ctrl = rd_idx == `RTCR_IDX_CTRL;
  wire rd_is_win = rd_idx == `RTCR_IDX_WIN;
  wire rd_is_rpt = rd_idx == `RTCR_IDX_REPEAT;
  wire rd_is_evt = rd_idx == `RTCR_IDX_EVENT;
  assign rd_win_hi = rd_take && rd_is_win;
  wire [31:0] ctrl_word = {27'h0, alarm_on_reg, chime_reg, unlock_reg, ptr_reg};
  wire [31:0] rd_word = rd_is_ctrl ? ctrl_word :
                        rd_is_win ? {16'h0000, win_hi, win_lo} :
                        rd_is_rpt ? {24'h000000, repeat_reg} : 32'h0000_0000;
  wire rd_ok = rd_is_ctrl || rd_is_win || rd_is_rpt || rd_is_evt;

  // Data is captured with the address, so the pointer step shows next read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= `RTCR_RESP_OKAY;
    end else if (rd_take) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_word;
      rresp_reg <= rd_ok ? `RTCR_RESP_OKAY : `RTCR_RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // Readies follow next-cycle hold state, so each ready leaves a flop
  wire bvalid_next = wr_fire || (bvalid_reg && !s_axi_bready);
  wire rvalid_next = rd_take || (rvalid_reg && !s_axi_rready);
  wire awready_next = !(aw_have && !wr_fire) && !bvalid_next;
  wire wready_next = !(w_have && !wr_fire) && !bvalid_next;
  wire arready_next = !rvalid_next;

  // Low through reset and the first two edges after release
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      arready_reg <= 1'b0;
    end else begin
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      arready_reg <= arready_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Straight from flops; one write and one read in flight at most
  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign alarm_on = alarm_on_reg;
  assign repeat_event = repeat_event_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_DEC: assert property (@(posedge clk) disable iff (!rst_n)
    (alarm_event && !wr_rpt && repeat_reg != 8'h00) |=> repeat_reg == $past(repeat_reg) - 8'h01)
    else $error("repeat counter did not decrement");
  AST_HOLD_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
    (alarm_event && !wr_rpt && repeat_reg == 8'h00 && !chime_reg) |=> repeat_reg == 8'h00)
    else $error("repeat counter wrapped without chime");
  AST_WRAP: assert property (@(posedge clk) disable iff (!rst_n)
    (alarm_event && !wr_rpt && repeat_reg == 8'h00 && chime_reg) |=> repeat_reg == 8'hff)
    else $error("chime wrap missing");
  AST_SW_WINS: assert property (@(posedge clk) disable iff (!rst_n)
    wr_rpt |=> repeat_reg == $past(wr_data[7:0]))
    else $error("software write lost");
  AST_ALARM_OFF: assert property (@(posedge clk) disable iff (!rst_n)
    (alarm_stop && !wr_ctrl) |=> !alarm_on)
    else $error("alarm enable not cleared");
  AST_PTR: assert property (@(posedge clk) disable iff (!rst_n)
    (hi_access && !wr_ctrl && ptr_reg != 2'h0) |=> ptr_reg == $past(ptr_reg) - 2'h1)
    else $error("pointer did not step");
  AST_PTR_PARK: assert property (@(posedge clk) disable iff (!rst_n)
    (hi_access && !wr_ctrl && ptr_reg == 2'h0) |=> ptr_reg == 2'h0)
    else $error("pointer left zero");
  AST_LOCK: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_win_lo && !unlock_reg && ptr_reg == RTCR_PTR_RSVD_YEAR) |=> $stable(year_reg))
    else $error("locked write changed year");
  AST_RSVD: assert property (@(posedge clk) disable iff (!rst_n)
    (rd_take && rd_is_win && ptr_reg == RTCR_PTR_RSVD_YEAR) |=> rdata_reg[15:8] == 8'h00)
    else $error("reserved slot not zero");
  AST_MIN_TOP: assert property (@(posedge clk) disable iff (!rst_n)
    (rd_take && rd_is_win && ptr_reg == RTCR_PTR_MIN_SEC) |=> rdata_reg[15] == 1'b0 && rdata_reg[7] == 1'b0)
    else $error("minute or second bit seven set");
  AST_BRESP: assert property (@(posedge clk) disable iff (!rst_n)
    wr_fire |=> s_axi_bvalid)
    else $error("write response missing");
  AST_UNLOCK_WR: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_win_lo && unlock_reg && ptr_reg == RTCR_PTR_RSVD_YEAR) |=> year_reg == $past(wd_lo))
    else $error("unlocked year write lost");
  AST_WEEKDAY_DIGIT_TOP: assert property (@(posedge clk) disable iff (!rst_n)
    (rd_take && rd_is_win && ptr_reg == RTCR_PTR_WEEKDAY_DIGIT_HOUR) |=> rdata_reg[15:11] == 5'h00)
    else $error("weekday upper bits set");
  AST_DAY_TOP: assert property (@(posedge clk) disable iff (!rst_n)
    (rd_take && rd_is_win && ptr_reg == RTCR_PTR_MONTH_DAY) |=> rdata_reg[15:13] == 3'h0 && rdata_reg[7:6] == 2'h0)
    else $error("month or day upper bits set");

  COV_WRAP: cover property (@(posedge clk) disable iff (!rst_n) alarm_event && chime_reg && repeat_reg == 8'h00);
  COV_STOP: cover property (@(posedge clk) disable iff (!rst_n) alarm_stop);
  COV_WALK: cover property (@(posedge clk) disable iff (!rst_n) rd_win_hi && ptr_reg == RTCR_PTR_RSVD_YEAR);
  COV_CLASH: cover property (@(posedge clk) disable iff (!rst_n) wr_rpt && alarm_event);

endmodule

// ### inc/rtcr_pkg.sv
// Types shared by the time register bank.
// Assumes the constants header is on the include path.
package rtcr_pkg;
  typedef enum logic [1:0] {
    RTCR_PTR_MIN_SEC,
    RTCR_PTR_WEEKDAY_DIGIT_HOUR,
    RTCR_PTR_MONTH_DAY,
    RTCR_PTR_RSVD_YEAR
  } rtcr_ptr_t;
  typedef enum logic {RTCR_IDLE, RTCR_RESP} rtcr_state_t;
endpackage

// ### inc/rtcr_regs.svh
// Register offsets, field positions and reset values of the time register bank.
// Assumes inclusion by bare name from the design file and the testbench.
`ifndef RTCR_REGS_SVH
`define RTCR_REGS_SVH
// Printed offset of the repeat counter is not a multiple of four: kept as index
`define RTCR_IDX_REPEAT 12'hf46
// Word indices seen by the address decoders
`define RTCR_IDX_CTRL 12'h000
`define RTCR_IDX_WIN 12'h001
`define RTCR_IDX_EVENT 12'h002
`define RTCR_ADDR_REPEAT 14'h3d18
`define RTCR_ADDR_CTRL 14'h0000
`define RTCR_ADDR_WIN 14'h0004
`define RTCR_ADDR_EVENT 14'h0008
`define RTCR_REPEAT_RST 8'h00
`define RTCR_PTR_RST 2'h0
// Control register fields
`define RTCR_CTRL_PTR_LO 0
`define RTCR_CTRL_UNLOCK 2
`define RTCR_CTRL_CHIME 3
`define RTCR_CTRL_ALARM_ON 4
// Window word fields
`define RTCR_WIN_LOW_LO 0
`define RTCR_WIN_HIGH_LO 8
// Used-bit masks of each time register
`define RTCR_MASK_YEAR 8'hff
`define RTCR_MASK_MONTH 8'h1f
`define RTCR_MASK_DAY 8'h3f
`define RTCR_MASK_WEEKDAY_DIGIT 8'h07
`define RTCR_MASK_HOUR 8'h3f
`define RTCR_MASK_MIN 8'h7f
`define RTCR_MASK_SEC 8'h7f
`define RTCR_RESP_OKAY 2'b00
`define RTCR_RESP_SLVERR 2'b10
`endif

// ### tb/testbench.sv
// Self-checking bench for the time register bank and alarm repeat counter.
// Assumes the package and the constants header are compiled and on the include path.
`include "rtcr_regs.svh"
`define CHECK(nm, ex, got) \
  begin \
    n_tests++; \
    if ((got) !== (ex)) begin \
      fails++; \
      $display("Error %s expected %h seen %h", nm, ex, got); \
    end \
  end
module testbench
  import rtcr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Signals and design
  // ----------------------------------------
  logic clk, resetn, alarm_event, alarm_on, repeat_event;
  logic [13:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_data;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int fails = 0;
  int n_tests = 0;
  int cycles = 0;
  // Window bytes written per pointer step 3..0, with unused bits set on purpose
  logic [15:0] win_wr [4] = '{16'hff99, 16'hf2f1, 16'hfee3, 16'hd9d8};
  logic [15:0] win_ex [4] = '{16'h0099, 16'h1231, 16'h0623, 16'h5958};
  rtcr_time_regs dut_u (.clk(clk), .resetn(resetn), .alarm_event(alarm_event),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .alarm_on(alarm_on),
    .repeat_event(repeat_event));
  // ----------------------------------------
  // Clock and hang guard
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Whole run needs well under a thousand cycles; the ceiling leaves room
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      complete_run();
    end
  end
  // ----------------------------------------
  // Bus tasks
  // ----------------------------------------
  // Address and data offered together; ev raises an alarm pulse in the same cycle
  task automatic axi_wr(input logic [13:0] a, input logic [31:0] d, input logic [3:0] s,
                        input logic ev, input logic [1:0] rexp);
    logic aw_done, w_done;
    int k;
    aw_done = 1'b0;
    w_done = 1'b0;
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    alarm_event <= ev;
    for (k = 0; k < 50; k++) begin
      @(posedge clk);
      if (k == 0) alarm_event <= 1'b0;
      if (s_axi_bvalid) break;
      if (!aw_done && s_axi_awready) begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_done && s_axi_wready) begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    `CHECK("write answer", 1'b1, k < 50)
    `CHECK("bresp", rexp, s_axi_bresp)
  endtask
  task automatic axi_rd(input logic [13:0] a, input logic [31:0] dexp, input logic [1:0] rexp);
    int k;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge clk);
      if (s_axi_rvalid) break;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    rd_data = s_axi_rdata;
    `CHECK("read answer", 1'b1, k < 50)
    `CHECK("rresp", rexp, s_axi_rresp)
    if (rexp === `RTCR_RESP_OKAY) `CHECK("rdata", dexp, rd_data)
  endtask
  // One alarm pulse; the repeat pulse, when expected, must show in exactly one of the next two cycles, else in neither
  task automatic alarm_pulse(input logic exp_rep);
    logic s1, s2;
    alarm_event <= 1'b1;
    @(posedge clk);
    alarm_event <= 1'b0;
    #1 s1 = repeat_event;
    @(posedge clk);
    #1 s2 = repeat_event;
    `CHECK("repeat pulse", {1'b0, exp_rep}, {s1 & s2, s1 | s2})
    @(posedge clk);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic reset_values();
    axi_rd(`RTCR_ADDR_REPEAT, 32'h0000_0000, `RTCR_RESP_OKAY);
    axi_rd(`RTCR_ADDR_CTRL, 32'h0000_0000, `RTCR_RESP_OKAY);
    `CHECK("alarm_on", 1'b0, alarm_on)
  endtask
  task automatic window_fill_and_read();
    int i;
    axi_wr(`RTCR_ADDR_CTRL, 32'h0000_0007, 4'h1, 1'b0, `RTCR_RESP_OKAY);
    for (i = 0; i < 4; i++) axi_wr(`RTCR_ADDR_WIN, {16'h0, win_wr[i]}, 4'h3, 1'b0, `RTCR_RESP_OKAY);
    axi_wr(`RTCR_ADDR_CTRL, 32'h0000_0007, 4'h1, 1'b0, `RTCR_RESP_OKAY);
    for (i = 0; i < 4; i++) axi_rd(`RTCR_ADDR_WIN, {16'h0, win_ex[i]}, `RTCR_RESP_OKAY);
    axi_rd(`RTCR_ADDR_WIN, {16'h0, win_ex[3]}, `RTCR_RESP_OKAY);
    axi_rd(`RTCR_ADDR_CTRL, 32'h0000_0004, `RTCR_RESP_OKAY);
  endtask
  task automatic locked_and_unmapped();
    axi_wr(`RTCR_ADDR_CTRL, 32'h0000_0000, 4'h1, 1'b0, `RTCR_RESP_OKAY);
    axi_wr(`RTCR_ADDR_WIN, 32'h0000_0000, 4'h3, 1'b0, `RTCR_RESP_OKAY);
    axi_rd(`RTCR_ADDR_WIN, {16'h0, win_ex[3]}, `RTCR_RESP_OKAY);
    // Locked low-lane write aimed at year; lane 0 alone leaves the pointer put
    axi_wr(`RTCR_ADDR_CTRL, 32'h0000_0003, 4'h1, 1'b0, `RTCR_RESP_OKAY);
    axi_wr(`RTCR_ADDR_WIN, 32'h0000_0000, 4'h1, 1'b0, `RTCR_RESP_OKAY);
    axi_rd(`RTCR_ADDR_WIN, {16'h0, win_ex[0]}, `RTCR_RESP_OKAY);
    axi_wr(14'h000c, 32'h0000_00a5, 4'hf, 1'b0, `RTCR_RESP_SLVERR);
    axi_rd(14'h0010, 32'h0000_0000, `RTCR_RESP_SLVERR);
    axi_wr(`RTCR_ADDR_EVENT, 32'h0000_00ff, 4'hf, 1'b0, `RTCR_RESP_OKAY);
    axi_rd(`RTCR_ADDR_EVENT, 32'h0000_0000, `RTCR_RESP_OKAY);
  endtask
  task automatic repeat_counting();
    axi_wr(`RTCR_ADDR_REPEAT, 32'h0000_0002, 4'h1, 1'b0, `RTCR_RESP_OKAY);
    axi_wr(`RTCR_ADDR_CTRL, 32'h0000_0010, 4'h1, 1'b0, `RTCR_RESP_OKAY);
    `CHECK("alarm_on", 1'b1, alarm_on)
    alarm_pulse(1'b1);
    axi_rd(`RTCR_ADDR_REPEAT, 32'h0000_0001, `RTCR_RESP_OKAY);
    alarm_pulse(1'b1);
    axi_rd(`RTCR_ADDR_REPEAT, 32'h0000_0000, `RTCR_RESP_OKAY);
    alarm_pulse(1'b1);
    axi_rd(`RTCR_ADDR_REPEAT, 32'h0000_0000, `RTCR_RESP_OKAY);
    `CHECK("alarm_on", 1'b0, alarm_on)
    alarm_pulse(1'b0);
  endtask
  task automatic chime_wrap_and_override();
    axi_wr(`RTCR_ADDR_CTRL, 32'h0000_0018, 4'h1, 1'b0, `RTCR_RESP_OKAY);
    alarm_pulse(1'b1);
    axi_rd(`RTCR_ADDR_REPEAT, 32'h0000_00ff, `RTCR_RESP_OKAY);
    `CHECK("alarm_on", 1'b1, alarm_on)
    axi_wr(`RTCR_ADDR_REPEAT, 32'h0000_0005, 4'h1, 1'b1, `RTCR_RESP_OKAY);
    axi_rd(`RTCR_ADDR_REPEAT, 32'h0000_0005, `RTCR_RESP_OKAY);
  endtask
  // ----------------------------------------
  // Main sequence and verdict
  // ----------------------------------------
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    resetn = 1'b0;
    alarm_event = 1'b0;
    s_axi_awaddr = 14'h0000;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'h0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 14'h0000;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    // Readies need three edges after release
    repeat (5) @(posedge clk);
    reset_values();
    window_fill_and_read();
    locked_and_unmapped();
    repeat_counting();
    chime_wrap_and_override();
    complete_run();
  end
endmodule
